// ### opamp_mux_settle_control_consts.svh
// Constants for the op amp mux and settle control block.
// Operation
// - Each amplifier has its own timer from enable until it reports ready.
// - Settle time is in microseconds, maximum 0x7F meaning 127 microseconds.
// - The settle allowance is counted after the warmup period.
// - When the settle time has elapsed, settle done goes from 0 to 1.
// - In event driven mode a ready pulse is emitted as settle done sets.
// - A write to the input or ladder mux register restarts that settle counter.
// - A write to the amplifier control register restarts that settle counter.
// - Driver mode OFF drives only under drive override event; NORMAL drives continuously.
// - While the driver is enabled the block owns the output pin.
// - Plus input offers pin, wiper, converter, ground, half supply, plus neighbour sources.
// - Minus input offers pin, own wiper, own output and converter output.
// - Ladder top offers off, own output or supply rail.
// - Ladder bottom offers off, pins, converter, ground and the neighbour output.
// - Wiper tap picks one of eight ladder positions 0 to 7.
// - Reduced input range bit set to 1 narrows every amplifier input range.
// - Writing 1 to the peripheral enable starts configured amplifiers and their counters.
// - In event driven mode the amplifier switches on at turn on event, off at turn off event.
// - With event control disabled only software on counts; events are ignored, none made.
`ifndef OPAMP_MUX_SETTLE_CONTROL_CONSTS_SVH
`define OPAMP_MUX_SETTLE_CONTROL_CONSTS_SVH

// ************************************************************
// Register map
// ************************************************************
`define OFS_CTRL           3'h0
`define OFS_TIMEBASE       3'h1
`define OFS_POWER          3'h2
`define OFS_INPUT_MUX      3'h0
`define OFS_LADDER_MUX     3'h1
`define OFS_AMP_CONTROL    3'h2
`define OFS_SETTLE         3'h3
`define OFS_AMP_STATUS     3'h4
`define MAP_TOP_BIT        7

// ************************************************************
// Field positions and codes
// ************************************************************
`define BIT_ENABLE         0
`define BIT_REDUCED_RANGE  0
`define BIT_SOFTWARE_ON    0
`define BIT_EVENT_ENABLE   1
`define BIT_DRIVER_MODE    2
`define POS_PLUS           0
`define POS_MINUS          4
`define POS_TOP            0
`define POS_BOTTOM         4
`define POS_WIPER          8
`define BIT_SETTLE_DONE    0
`define BIT_AMP_ON         1
`define PLUS_GROUND        3'h3
`define PLUS_BASE_MAX      3'h4
`define TOP_OFF            2'h0
`define TOP_MAX            2'h2
`define BOTTOM_OFF         3'h0
`define BOTTOM_MAX         3'h5

// ************************************************************
// Reset values and timing
// ************************************************************
`define RST_TIMEBASE       8'h00
`define RST_SETTLE         7'h7F
`define AMP_WARMUP_US      9'h00A

`endif

// ### opamp_pkg.sv
// Types shared by the op amp mux and settle control block.
package opamp_pkg;
    typedef enum logic {DRIVE_OFF, DRIVE_NORMAL} drive_mode_e;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_READ_WAIT, BUS_READ_DONE} bus_state_e;
endpackage

// ### us_tick_gen.sv
// Free-running microsecond prescaler.
`include "opamp_mux_settle_control_consts.svh"
module us_tick_gen (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] usTickDivider,
    output logic            usTick
);
    logic [7:0] count_reg;

    // A divider lowered below the current count is missed until the count wraps past 255, so the
    // first tick after such a write may come late by up to 256 cycles.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 8'h00;
            usTick    <= 1'b0;
        end else begin
            count_reg <= (count_reg == usTickDivider) ? 8'h00 : 8'(count_reg + 8'h01);
            usTick    <= (count_reg == usTickDivider);
        end
    end
endmodule // us_tick_gen

// ### amp_settle_timer.sv
// Per-amplifier enable tracking and settle timer.
`include "opamp_mux_settle_control_consts.svh"
module amp_settle_timer (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       periphEnable,
    input  wire logic       softwareOn,
    input  wire logic       eventControlEnable,
    input  wire logic       turnOnEvent,
    input  wire logic       turnOffEvent,
    input  wire logic       restartSettle,
    input  wire logic       usTick,
    input  wire logic [6:0] settleTimeUs,
    output logic            ampOn,
    output logic            settleDone,
    output logic            readyPulse
);
    logic       eventOn_reg;
    logic       onPrev_reg;
    logic [8:0] count_reg;

    wire       eventDriven = eventControlEnable & ~softwareOn;
    wire [8:0] target      = 9'(`AMP_WARMUP_US + {2'b00, settleTimeUs});
    wire [8:0] countInc    = 9'(count_reg + 9'h001);
    wire       startNow    = ampOn & ~onPrev_reg;
    wire       clearCount  = ~ampOn | restartSettle | startNow;
    // Turn on wins over a simultaneous turn off.
    wire       eventOnNext = turnOnEvent ? 1'b1 : (turnOffEvent ? 1'b0 : eventOn_reg);
    wire       doneNext    = ~clearCount & (settleDone | (usTick & (countInc >= target)));

    assign ampOn = periphEnable & (eventDriven ? eventOn_reg : softwareOn);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventOn_reg <= 1'b0;
            onPrev_reg  <= 1'b0;
            count_reg   <= 9'h000;
            settleDone  <= 1'b0;
            readyPulse  <= 1'b0;
        end else begin
            eventOn_reg <= eventDriven ? eventOnNext : eventOn_reg;
            onPrev_reg  <= ampOn;
            count_reg   <= clearCount ? 9'h000 : ((usTick & ~settleDone) ? countInc : count_reg);
            settleDone  <= doneNext;
            // A turn on event to an already settle_done amplifier answers at once.
            readyPulse  <= eventDriven & doneNext & (~settleDone | turnOnEvent);
        end
    end
endmodule // amp_settle_timer

// ### opamp_mux_settle_control.sv
// Register file, bus slave and per-amplifier control for three op amps.
//
// The AHB-Lite register port and the register offsets were decided locally.
`include "opamp_mux_settle_control_consts.svh"
module opamp_mux_settle_control
    import opamp_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic [2:0]  turnOnEvent,
    input  wire logic [2:0]  turnOffEvent,
    input  wire logic [2:0]  driveOverrideEvent,
    output logic [2:0]       readyPulse,
    output logic [8:0]       plusInputSelect,
    output logic [5:0]       minusInputSelect,
    output logic [5:0]       ladderTopSelect,
    output logic [8:0]       ladderBottomSelect,
    output logic [8:0]       wiperTapSelect,
    output logic [2:0]       outputDriveEnable,
    output logic [2:0]       ampPowered,
    output logic             reducedInputRange
);
    // ************************************************************
    // Bus slave
    // ************************************************************
    bus_state_e  state_reg;
    bus_state_e  state_next;
    logic [7:0]  addr_reg;
    logic        mapped_reg;
    logic [31:0] readWord;
    logic [31:0] blockRead [4];

    wire       accept   = hsel & htrans[1] & hready;
    wire [1:0] accBlock = addr_reg[6:5];
    wire [2:0] accIndex = addr_reg[4:2];
    wire       wrActive = (state_reg == BUS_WRITE) & mapped_reg;
    wire       wrGlobal = wrActive & (accBlock == 2'h0);

    // Reads take one wait state so that the read data come from a flip-flop.
    assign hreadyout = (state_reg != BUS_READ_WAIT);
    assign hresp     = 1'b0;
    assign readWord  = mapped_reg ? blockRead[accBlock] : 32'h0000_0000;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            BUS_READ_WAIT: begin
                state_next = BUS_READ_DONE;
            end
            BUS_IDLE, BUS_WRITE, BUS_READ_DONE: begin
                if (accept) begin
                    state_next = hwrite ? BUS_WRITE : BUS_READ_WAIT;
                end else if (hready) begin
                    state_next = BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= BUS_IDLE;
            addr_reg   <= 8'h00;
            mapped_reg <= 1'b0;
            hrdata     <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            if (accept) begin
                addr_reg   <= haddr[7:0];
                mapped_reg <= (haddr[31:`MAP_TOP_BIT] == 25'h0);
            end
            if (state_reg == BUS_READ_WAIT) begin
                hrdata <= readWord;
            end
        end
    end

    // ************************************************************
    // Global registers
    // ************************************************************
    logic       enable_reg;
    logic [7:0] timebase_reg;
    logic       power_reg;
    logic       usTick;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_reg   <= 1'b0;
            timebase_reg <= `RST_TIMEBASE;
            power_reg    <= 1'b0;
        end else if (wrGlobal) begin
            if (accIndex == `OFS_CTRL) begin
                enable_reg <= hwdata[`BIT_ENABLE];
            end
            if (accIndex == `OFS_TIMEBASE) begin
                timebase_reg <= hwdata[7:0];
            end
            if (accIndex == `OFS_POWER) begin
                power_reg <= hwdata[`BIT_REDUCED_RANGE];
            end
        end
    end

    assign reducedInputRange = power_reg;
    assign blockRead[0] = (accIndex == `OFS_CTRL)     ? {31'h0, enable_reg} :
                          (accIndex == `OFS_TIMEBASE) ? {24'h0, timebase_reg} :
                          (accIndex == `OFS_POWER)    ? {31'h0, power_reg} : 32'h0000_0000;

    us_tick_gen tickGen (
        .core_clk      (core_clk),
        .rst_n         (rst_n),
        .usTickDivider (timebase_reg),
        .usTick        (usTick)
    );

    // ************************************************************
    // Per-amplifier registers and control
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gAmp
            logic [2:0]  plus_reg;
            logic [1:0]  minus_reg;
            logic [1:0]  top_reg;
            logic [2:0]  bottom_reg;
            logic [2:0]  wiper_reg;
            logic        softwareOn_reg;
            logic        eventEnable_reg;
            drive_mode_e driveMode_reg;
            logic [6:0]  settle_reg;
            logic        drive_reg;
            logic        ampOn;
            logic        settleDone;

            wire       wrThis   = wrActive & (accBlock == 2'(g + 1));
            wire       wrInput  = wrThis & (accIndex == `OFS_INPUT_MUX);
            wire       wrLadder = wrThis & (accIndex == `OFS_LADDER_MUX);
            wire       wrCtrl   = wrThis & (accIndex == `OFS_AMP_CONTROL);
            wire       restart  = wrInput | wrLadder | wrCtrl;
            wire [2:0] plusIn   = hwdata[`POS_PLUS +: 3];
            wire [1:0] topIn    = hwdata[`POS_TOP +: 2];
            wire [2:0] botIn    = hwdata[`POS_BOTTOM +: 3];
            // Amplifier 0 has five plus sources, amplifier 1 six, amplifier 2 seven.
            wire [2:0] plusMax  = 3'(`PLUS_BASE_MAX + g);
            wire       driveNow = ampOn & ((driveMode_reg == DRIVE_NORMAL) |
                                          (eventEnable_reg & driveOverrideEvent[g]));

            // Codes a given amplifier lacks are stored as a safe source instead.
            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    plus_reg   <= `PLUS_GROUND;
                    minus_reg  <= 2'h0;
                    top_reg    <= `TOP_OFF;
                    bottom_reg <= `BOTTOM_OFF;
                    wiper_reg  <= 3'h0;
                end else begin
                    if (wrInput) begin
                        plus_reg  <= (plusIn <= plusMax) ? plusIn : `PLUS_GROUND;
                        minus_reg <= hwdata[`POS_MINUS +: 2];
                    end
                    if (wrLadder) begin
                        top_reg    <= (topIn <= `TOP_MAX) ? topIn : `TOP_OFF;
                        bottom_reg <= (botIn <= `BOTTOM_MAX) ? botIn : `BOTTOM_OFF;
                        wiper_reg  <= hwdata[`POS_WIPER +: 3];
                    end
                end
            end

            always_ff @(posedge core_clk or negedge rst_n) begin
                if (!rst_n) begin
                    softwareOn_reg  <= 1'b0;
                    eventEnable_reg <= 1'b0;
                    driveMode_reg   <= DRIVE_OFF;
                    settle_reg      <= `RST_SETTLE;
                    drive_reg       <= 1'b0;
                end else begin
                    if (wrCtrl) begin
                        softwareOn_reg  <= hwdata[`BIT_SOFTWARE_ON];
                        eventEnable_reg <= hwdata[`BIT_EVENT_ENABLE];
                        driveMode_reg   <= drive_mode_e'(hwdata[`BIT_DRIVER_MODE]);
                    end
                    if (wrThis & (accIndex == `OFS_SETTLE)) begin
                        settle_reg <= hwdata[6:0];
                    end
                    drive_reg <= driveNow;
                end
            end

            amp_settle_timer timer (
                .core_clk           (core_clk),
                .rst_n              (rst_n),
                .periphEnable       (enable_reg),
                .softwareOn         (softwareOn_reg),
                .eventControlEnable (eventEnable_reg),
                .turnOnEvent        (turnOnEvent[g]),
                .turnOffEvent       (turnOffEvent[g]),
                .restartSettle      (restart),
                .usTick             (usTick),
                .settleTimeUs       (settle_reg),
                .ampOn              (ampOn),
                .settleDone         (settleDone),
                .readyPulse         (readyPulse[g])
            );

            assign plusInputSelect[3*g +: 3]    = plus_reg;
            assign minusInputSelect[2*g +: 2]   = minus_reg;
            assign ladderTopSelect[2*g +: 2]    = top_reg;
            assign ladderBottomSelect[3*g +: 3] = bottom_reg;
            assign wiperTapSelect[3*g +: 3]     = wiper_reg;
            assign outputDriveEnable[g]         = drive_reg;
            assign ampPowered[g]                = ampOn;
            assign blockRead[g + 1] =
                (accIndex == `OFS_INPUT_MUX)   ? {26'h0, minus_reg, 1'b0, plus_reg} :
                (accIndex == `OFS_LADDER_MUX)  ? {21'h0, wiper_reg, 1'b0, bottom_reg, 2'h0, top_reg} :
                (accIndex == `OFS_AMP_CONTROL) ? {29'h0, driveMode_reg, eventEnable_reg, softwareOn_reg} :
                (accIndex == `OFS_SETTLE)      ? {25'h0, settle_reg} :
                (accIndex == `OFS_AMP_STATUS)  ? {30'h0, ampOn, settleDone} : 32'h0000_0000;
        end
    endgenerate
endmodule // opamp_mux_settle_control

// ### opamp_monitor.sv
// Port checker for the op amp mux and settle control block.
module opamp_monitor (
    input wire logic       core_clk,
    input wire logic       rst_n,
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic [2:0] readyPulse,
    input wire logic [2:0] ampPowered,
    input wire logic [8:0] plusInputSelect,
    input wire logic [5:0] ladderTopSelect,
    input wire logic [8:0] ladderBottomSelect,
    input wire logic       reducedInputRange
);
    // ************************************************************
    // Assertions
    // ************************************************************
    wire logic wrTake = hsel && htrans[1] && hready && hwrite;
    wire logic rdTake = hsel && htrans[1] && hready && !hwrite;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    chk_resp_okay: assert property (hresp == 1'b0)
        else $error("Bus response is not OKAY.");
    chk_read_wait: assert property (rdTake |=> !hreadyout ##1 hreadyout)
        else $error("Read did not take exactly one wait cycle.");
    chk_write_nowait: assert property (wrTake |=> hreadyout)
        else $error("Write inserted a wait cycle.");
    chk_pulse_single: assert property (|readyPulse |=> (readyPulse & $past(readyPulse)) == 3'h0)
        else $error("Ready pulse lasted more than one cycle.");
    chk_pulse_powered: assert property ((readyPulse & ~ampPowered) == 3'h0)
        else $error("Ready pulse from an amplifier that is off.");
    chk_warmup_first: assert property (readyPulse[1] |-> $past(ampPowered[1], 9))
        else $error("Ready pulse came before the warmup could pass.");
    chk_plus_legal: assert property (plusInputSelect[2:0] <= 3'h4 && plusInputSelect[5:3] <= 3'h5
        && plusInputSelect[8:6] <= 3'h6) else $error("Plus input code out of range.");
    chk_top_legal: assert property ((ladderTopSelect[1:0] != 2'h3) && (ladderTopSelect[3:2] != 2'h3)
        && (ladderTopSelect[5:4] != 2'h3)) else $error("Ladder top code out of range.");
    chk_bottom_legal: assert property (ladderBottomSelect[2:0] <= 3'h5 && ladderBottomSelect[5:3] <= 3'h5
        && ladderBottomSelect[8:6] <= 3'h5) else $error("Ladder bottom code out of range.");
    chk_range_write: assert property ($changed(reducedInputRange) |-> $past(wrTake, 2))
        else $error("Input range changed without a write.");
    cover property (rdTake);
    cover property (readyPulse[1]);
    cover property (reducedInputRange);
endmodule // opamp_monitor

bind opamp_mux_settle_control opamp_monitor u_mon (.core_clk, .rst_n, .hsel, .htrans, .hwrite, .hready,
    .hreadyout, .hresp, .readyPulse, .ampPowered, .plusInputSelect, .ladderTopSelect, .ladderBottomSelect,
    .reducedInputRange);

// ### event_net.sv
// Behavioural event network that drives the amplifier events.
module event_net (
    input  wire logic       core_clk,
    input  wire logic [2:0] readyPulse,
    output logic      [2:0] turnOnEvent,
    output logic      [2:0] turnOffEvent,
    output logic      [2:0] driveOverrideEvent
);
    int readyCount [3] = '{0, 0, 0};
    initial begin
        turnOnEvent = 3'h0;
        turnOffEvent = 3'h0;
        driveOverrideEvent = 3'h0;
    end
    // One edge per event keeps each turn on or turn off request a single-cycle pulse.
    always @(posedge core_clk) begin
        for (int i = 0; i < 3; i++) if (readyPulse[i] === 1'b1) readyCount[i]++;
    end
    task automatic pulse(input int kind, input int idx);
        @(posedge core_clk);
        if (kind == 0) turnOnEvent[idx] <= 1'b1;
        else turnOffEvent[idx] <= 1'b1;
        @(posedge core_clk);
        turnOnEvent <= 3'h0;
        turnOffEvent <= 3'h0;
    endtask
    task automatic setDrive(input int idx, input logic v);
        @(posedge core_clk);
        driveOverrideEvent[idx] <= v;
    endtask
endmodule // event_net

// ### testbench.sv
// Self-checking testbench for the op amp mux and settle control block.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ************************************************************
    // Signals
    // ************************************************************
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        hsel = 1'b0, hwrite = 1'b0, rdPhase = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rv, cfgIn, cfgLad;
    logic        hreadyout, hresp, reducedInputRange;
    logic [2:0]  turnOnEvent, turnOffEvent, driveOverrideEvent, readyPulse, outputDriveEnable, ampPowered;
    logic [8:0]  plusInputSelect, ladderBottomSelect, wiperTapSelect;
    logic [5:0]  minusInputSelect, ladderTopSelect;
    logic [63:0] expQ [$];
    logic [63:0] note;
    int          mismatches = 0, cmp_count = 0, n, t0;

    always #50 core_clk = ~core_clk;

    opamp_mux_settle_control dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata, .turnOnEvent, .turnOffEvent, .driveOverrideEvent,
        .readyPulse, .plusInputSelect, .minusInputSelect, .ladderTopSelect, .ladderBottomSelect,
        .wiperTapSelect, .outputDriveEnable, .ampPowered, .reducedInputRange);
    event_net evt (.core_clk, .readyPulse, .turnOnEvent, .turnOffEvent, .driveOverrideEvent);

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rv = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask
    // A zero mask notes a poll whose data is only looked at by the caller.
    task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        expQ.push_back({m, e});
        xfer(a, 1'b0, 32'h0);
    endtask
    task automatic waitSettle(input logic [31:0] a);
        n = 0;
        do begin
            rd(a, 32'h0, 32'h0);
            n++;
        end while (rv[0] !== 1'b1 && n < 100);
    endtask

    // ************************************************************
    // Read data monitor
    // ************************************************************
    always @(posedge core_clk) begin
        if (rdPhase && hreadyout === 1'b1 && expQ.size() > 0) begin
            note = expQ.pop_front();
            check(hrdata & note[63:32], note[31:0]);
        end
        if (hreadyout === 1'b1) rdPhase = hsel && htrans[1] && !hwrite;
    end

    initial begin
        #2000000;
        mismatches++;
        test_done;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        rv = $urandom(26164);
        rd(32'h04, 32'hFF, 32'h0);
        rd(32'h2C, 32'h7F, 32'h7F);
        rd(32'h30, 32'h3, 32'h0);
        check(plusInputSelect, 32'h0DB);
        wr(32'h104, 32'h1);
        rd(32'h104, 32'hFFFFFFFF, 32'h0);
        rd(32'h1C, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(32'h24, (i << 8) | (i << 4) | (i % 4));
            if (i < 7) wr(32'h60, ((i % 4) << 4) | i);
            @(posedge core_clk);
            check(wiperTapSelect[2:0], i);
            check(ladderBottomSelect[2:0], (i < 6) ? i : 0);
            check(ladderTopSelect[1:0], (i % 4 == 3) ? 0 : i % 4);
            check(plusInputSelect[8:6], i < 7 ? i : 6);
            check(minusInputSelect[5:4], (i < 7 ? i : 6) % 4);
        end
        wr(32'h20, 32'h7);
        @(posedge core_clk);
        check(plusInputSelect[2:0], 32'h3);
        wr(32'h04, 32'h9);
        cfgIn = (($urandom % 4) << 4) | ($urandom % 5);
        cfgLad = (($urandom % 8) << 8) | (($urandom % 6) << 4) | ($urandom % 3);
        wr(32'h20, cfgIn);
        wr(32'h24, cfgLad);
        wr(32'h08, 32'h1);
        @(posedge core_clk);
        check(plusInputSelect[2:0], cfgIn[2:0]);
        check(minusInputSelect[1:0], cfgIn[5:4]);
        check(reducedInputRange, 32'h1);
        rd(32'h24, 32'h777, cfgLad);
        wr(32'h28, 32'h5);
        wr(32'h2C, 32'h1);
        check(ampPowered[0], 32'h0);
        t0 = $time;
        wr(32'h00, 32'h1);
        waitSettle(32'h30);
        check(($time - t0) / 100 >= 100 && ($time - t0) / 100 <= 135, 32'h1);
        check(rv[0], 32'h1);
        check(outputDriveEnable[0], 32'h1);
        check(evt.readyCount[0], 32'h0);
        wr(32'h20, cfgIn);
        rd(32'h30, 32'h1, 32'h0);
        waitSettle(32'h30);
        wr(32'h28, 32'h5);
        rd(32'h30, 32'h1, 32'h0);
        evt.pulse(1, 0);
        @(posedge core_clk);
        check(ampPowered[0], 32'h1);
        wr(32'h48, 32'h2);
        wr(32'h4C, 32'h0);
        check(ampPowered[1], 32'h0);
        evt.pulse(0, 1);
        @(posedge core_clk);
        check(ampPowered[1], 32'h1);
        n = 0;
        while (evt.readyCount[1] == 0 && n < 300) begin
            @(posedge core_clk);
            n++;
        end
        check(evt.readyCount[1], 32'h1);
        check(outputDriveEnable[1], 32'h0);
        evt.setDrive(1, 1'b1);
        repeat (3) @(posedge core_clk);
        check(outputDriveEnable[1], 32'h1);
        evt.setDrive(1, 1'b0);
        evt.pulse(0, 1);
        repeat (3) @(posedge core_clk);
        check(evt.readyCount[1], 32'h2);
        evt.pulse(1, 1);
        @(posedge core_clk);
        check(ampPowered[1], 32'h0);
        wr(32'h48, 32'h3);
        evt.pulse(1, 1);
        @(posedge core_clk);
        check(ampPowered[1], 32'h1);
        evt.setDrive(1, 1'b1);
        repeat (3) @(posedge core_clk);
        check(outputDriveEnable[1], 32'h1);
        evt.setDrive(1, 1'b0);
        repeat (3) @(posedge core_clk);
        check(outputDriveEnable[1], 32'h0);
        test_done;
    end
endmodule // testbench
